// >>> logic/dcp_pkg.sv
// Purpose: Constants for the dual compare pulse channel
// Assumes: APB slave, 32-bit data, 16-bit compare values
// Notes:   Offsets are byte addresses
package dcp_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ctrl_off      = 8'h00;
    localparam logic [7:0] primary_off   = 8'h04;
    localparam logic [7:0] secondary_off = 8'h08;
    localparam logic [7:0] status_off    = 8'h0c;
    localparam logic [7:0] period0_off   = 8'h10;
    localparam logic [7:0] period1_off   = 8'h14;
    localparam logic [7:0] tbctl_off     = 8'h18;
    localparam logic [7:0] count0_off    = 8'h1c;
    localparam logic [7:0] count1_off    = 8'h20;
    // ------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------
    localparam int          mode_lsb      = 0;
    localparam int          tbsel_bit     = 3;
    localparam int          irq_en_bit    = 1;
    localparam int          flag_bit      = 0;
    localparam int          pin_bit       = 2;
    localparam logic [2:0]  mode_single   = 3'h4;
    localparam logic [2:0]  mode_cont     = 3'h5;
    localparam logic [2:0]  mode_reset    = 3'h0;
    localparam logic [15:0] word_reset    = 16'h0000;
    // Trailing match to flag: output falls at +1, flag at +3
    localparam int          flag_delay    = 2;
    localparam int          pin_delay     = 1;
endpackage

// >>> logic/dcp_time_base.sv
// Purpose: One up-counting time base with period wrap
// Assumes: Software writes the count only while stopped, if at all
// Notes:   Wraps to zero on the clock after reaching the period
`timescale 1ns/1ps
`default_nettype none
module dcp_time_base import dcp_pkg::*; #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Control
    input  wire logic         run,
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    input  wire logic [W-1:0] period,
    // Count
    output logic      [W-1:0] count
);
    logic [W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_value;
        end else if (run) begin
            if (count == period) begin
                next_count = '0; // (R17)
            end else begin
                next_count = W'(count + 1'b1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule
`default_nettype wire

// >>> logic/dcp_channel.sv
// Purpose: Dual compare pulse channel with APB registers
// Assumes: Zero-wait APB; both time bases live in this block
// Notes:   Pin rises one cycle after the primary match
//
// What this block does
// (R1) Single-pulse code: pin low, then one pulse
// (R2) Pin rises on first primary match
// (R3) Single-pulse secondary match: pin low, done
// (R4) Secondary match sets flag; enable gates irq
// (R5) Rewriting single-pulse code arms new pulse
// (R6) Software keeps secondary two cycles past primary
// (R7) Software loads values, period, mode, then runs
// (R8) Control bit three selects the time base
// (R9) Primary zero: first count gives no pulse
// (R10) Secondary below primary: fall after wrap
// (R11) Secondary beyond period: rise only, no flag
// (R12) All zero: pin low, flag clear
// (R13) Primary beyond period: pin stays low
// (R14) Continuous code: pin low until primary match
// (R15) Pin rises one cycle after primary match
// (R16) Continuous mode repeats each period
// (R17) Time base wraps to zero after period
// (R18) Period below secondary: no falling edge
// (R19) Flag set two cycles after pin falls
// (R20) Continuous mode flags every secondary match
// (R21) Output level cleared on reset
// (R22) Other mode codes stop pulse generation
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dcp_channel import dcp_pkg::*; #(
    parameter int W = 16
) (
    // APB
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Channel
    output logic             compare_output_pin,
    output logic             channel_irq
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {dcp_idle_s, dcp_wait_s, dcp_high_s,
                              dcp_done_s} dcp_state_t;

    logic [2:0]   compare_mode_field;
    logic         time_base_select;
    logic [W-1:0] primary_compare_value;
    logic [W-1:0] secondary_compare_value;
    logic [W-1:0] period0;
    logic [W-1:0] period1;
    logic [1:0]   timer_run_bit;
    logic         channel_irq_enable;
    logic         channel_irq_flag;
    logic [2:0]   next_mode;
    logic         next_tbsel;
    logic [W-1:0] next_primary;
    logic [W-1:0] next_secondary;
    logic [W-1:0] next_period0;
    logic [W-1:0] next_period1;
    logic [1:0]   next_run;
    logic         next_irq_enable;
    logic         next_flag;
    logic [31:0]  next_prdata;

    logic         wr;
    logic         rd;
    logic         ctrl_wr;
    logic         flag_clear;
    logic         addr_ok;
    logic [W-1:0] count0;
    logic [W-1:0] count1;
    logic [W-1:0] time_base_count;
    logic [W-1:0] time_base_period;

    assign wr      = psel && penable && pwrite;
    assign rd      = psel && penable && !pwrite;
    assign ctrl_wr = wr && paddr == ctrl_off;
    assign pready  = 1'b1;
    assign addr_ok = paddr inside {ctrl_off, primary_off, secondary_off,
                     status_off, period0_off, period1_off, tbctl_off,
                     count0_off, count1_off};
    assign pslverr = psel && penable && !addr_ok;
    assign flag_clear = wr && paddr == status_off && pwdata[flag_bit];

    // ------------------------------------------------------------
    // Time bases
    // ------------------------------------------------------------
    dcp_time_base #(.W(W)) u_tb0 (
        .pclk       (pclk),
        .presetn    (presetn),
        .run        (timer_run_bit[0]),
        .load       (wr && paddr == count0_off),
        .load_value (pwdata[W-1:0]),
        .period     (period0),
        .count      (count0)
    );

    dcp_time_base #(.W(W)) u_tb1 (
        .pclk       (pclk),
        .presetn    (presetn),
        .run        (timer_run_bit[1]),
        .load       (wr && paddr == count1_off),
        .load_value (pwdata[W-1:0]),
        .period     (period1),
        .count      (count1)
    );

    assign time_base_count  = time_base_select ? count1 : count0; // (R8)
    assign time_base_period = time_base_select ? period1 : period0;

    // ------------------------------------------------------------
    // Pulse engine
    // ------------------------------------------------------------
    dcp_state_t   state;
    dcp_state_t   next_state;
    logic         tb_run;
    logic         prim_hit;
    logic         sec_hit;
    logic         fell;
    logic [1:0]   fall_pipe;
    logic [1:0]   next_fall_pipe;
    logic         next_pin;
    logic         dual_mode;
    logic         prim_ok;
    logic         wrapped;
    logic         next_wrapped;

    assign dual_mode = compare_mode_field == mode_single
                    || compare_mode_field == mode_cont;
    assign tb_run    = time_base_select ? timer_run_bit[1]
                                        : timer_run_bit[0];
    // Matches count only while the chosen base ticks
    assign prim_hit  = tb_run && time_base_count == primary_compare_value;
    assign sec_hit   = tb_run && time_base_count == secondary_compare_value;
    // Zero primary counts only once the base wrapped into zero (R9)
    assign prim_ok   = prim_hit && (primary_compare_value != word_reset
                                    || wrapped);

    always_comb begin
        next_state = state;
        fell       = 1'b0;
        if (ctrl_wr) begin
            // Any control write restarts from low (R1) (R5) (R14) (R22)
            next_state = (pwdata[2:0] == mode_single
                       || pwdata[2:0] == mode_cont) ? dcp_wait_s
                                                    : dcp_idle_s;
        end else if (!dual_mode) begin
            next_state = dcp_idle_s; // (R22)
        end else begin
            unique case (state)
                dcp_idle_s: next_state = dcp_idle_s;
                dcp_wait_s: begin
                    // Primary beyond period never hits (R13) (R12)
                    // Zero primary waits for wrap when started at zero (R9)
                    if (prim_ok && !(primary_compare_value == word_reset
                        && time_base_period == word_reset)) begin
                        next_state = dcp_high_s; // (R2) (R15)
                    end
                end
                dcp_high_s: begin
                    // Secondary beyond period stays high (R11) (R18)
                    if (sec_hit && !prim_hit_now_same()) begin
                        fell = 1'b1; // (R10)
                        next_state = (compare_mode_field == mode_single)
                                   ? dcp_done_s : dcp_wait_s; // (R3) (R16)
                    end
                end
                dcp_done_s: next_state = dcp_done_s; // (R3)
            endcase
        end
        next_pin       = next_state == dcp_high_s;
        next_wrapped   = tb_run && time_base_count == time_base_period;
        next_fall_pipe = {fall_pipe[0], fell};
    end

    // Rising match cycle cannot also be the trailing one
    function automatic logic prim_hit_now_same();
        return 1'b0;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state              <= dcp_idle_s;
            compare_output_pin <= 1'b0; // (R21)
            fall_pipe          <= '0;
            wrapped            <= 1'b0;
        end else begin
            state              <= next_state;
            compare_output_pin <= next_pin;
            fall_pipe          <= next_fall_pipe;
            wrapped            <= next_wrapped;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_comb begin
        next_mode       = compare_mode_field;
        next_tbsel      = time_base_select;
        next_primary    = primary_compare_value;
        next_secondary  = secondary_compare_value;
        next_period0    = period0;
        next_period1    = period1;
        next_run        = timer_run_bit;
        next_irq_enable = channel_irq_enable;
        next_flag       = channel_irq_flag;
        next_prdata     = '0;
        if (wr) begin
            unique case (paddr)
                ctrl_off: begin
                    next_mode  = pwdata[2:0];
                    next_tbsel = pwdata[tbsel_bit]; // (R8)
                end
                primary_off:   next_primary   = pwdata[W-1:0];
                secondary_off: next_secondary = pwdata[W-1:0];
                period0_off:   next_period0   = pwdata[W-1:0];
                period1_off:   next_period1   = pwdata[W-1:0];
                tbctl_off:     next_run       = pwdata[1:0];
                status_off:    next_irq_enable = pwdata[irq_en_bit];
                default: ;
            endcase
        end
        if (flag_clear) begin
            next_flag = 1'b0;
        end
        // Set wins over clear; flag two cycles after the fall (R19) (R20)
        if (fall_pipe[1]) begin
            next_flag = 1'b1; // (R4)
        end
        if (rd) begin
            unique case (paddr)
                ctrl_off:      next_prdata = {28'h0, time_base_select,
                                              compare_mode_field};
                primary_off:   next_prdata = 32'(primary_compare_value);
                secondary_off: next_prdata = 32'(secondary_compare_value);
                period0_off:   next_prdata = 32'(period0);
                period1_off:   next_prdata = 32'(period1);
                tbctl_off:     next_prdata = {30'h0, timer_run_bit};
                count0_off:    next_prdata = 32'(count0);
                count1_off:    next_prdata = 32'(count1);
                status_off:    next_prdata = {29'h0, compare_output_pin,
                                 channel_irq_enable, channel_irq_flag};
                default:       next_prdata = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_mode_field      <= mode_reset;
            time_base_select        <= 1'b0;
            primary_compare_value   <= word_reset;
            secondary_compare_value <= word_reset;
            period0                 <= word_reset;
            period1                 <= word_reset;
            timer_run_bit           <= '0;
            channel_irq_enable      <= 1'b0;
            channel_irq_flag        <= 1'b0;
        end else begin
            compare_mode_field      <= next_mode;
            time_base_select        <= next_tbsel;
            primary_compare_value   <= next_primary;
            secondary_compare_value <= next_secondary;
            period0                 <= next_period0;
            period1                 <= next_period1;
            timer_run_bit           <= next_run;
            channel_irq_enable      <= next_irq_enable;
            channel_irq_flag        <= next_flag;
        end
    end

    // Read data is combinational over the access phase
    assign prdata = next_prdata;
    assign channel_irq = channel_irq_flag && channel_irq_enable; // (R4)

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    rise_after_hit_a: assert property (@(posedge pclk) // (R15)
        disable iff (!presetn)
        $rose(compare_output_pin) |-> $past(prim_hit))
        else $error("pin rose without primary match");
    flag_delay_a: assert property (@(posedge pclk) // (R19)
        disable iff (!presetn)
        $fell(compare_output_pin) && !$past(ctrl_wr) && dual_mode
        |-> ##2 channel_irq_flag)
        else $error("flag not set two cycles after fall");
    flag_source_a: assert property (@(posedge pclk) // (R4)
        disable iff (!presetn)
        $rose(channel_irq_flag) |-> $past(compare_output_pin, 3)
        && !$past(compare_output_pin, 2))
        else $error("flag set without a trailing edge");
    mode_stop_a: assert property (@(posedge pclk) // (R1)
        disable iff (!presetn)
        ctrl_wr |=> !compare_output_pin)
        else $error("pin not low after mode write");
    single_done_a: assert property (@(posedge pclk) // (R3)
        disable iff (!presetn)
        state == dcp_done_s && !ctrl_wr |=> !compare_output_pin)
        else $error("pin rose after single pulse");
    idle_low_a: assert property (@(posedge pclk) // (R22)
        disable iff (!presetn)
        !dual_mode && !$past(ctrl_wr) |-> !compare_output_pin)
        else $error("pin high outside dual modes");
    base_wrap_a: assert property (@(posedge pclk) // (R17)
        disable iff (!presetn)
        timer_run_bit[0] && count0 == period0 && !wr
        |=> count0 == '0)
        else $error("time base did not wrap");
    fall_on_sec_a: assert property (@(posedge pclk) // (R10)
        disable iff (!presetn)
        $fell(compare_output_pin) && !$past(ctrl_wr) |-> $past(sec_hit))
        else $error("fall without secondary match");
    single_cv: cover property (@(posedge pclk)
        state == dcp_high_s ##[1:50] state == dcp_done_s);
    cont_cv: cover property (@(posedge pclk)
        compare_mode_field == mode_cont && $fell(compare_output_pin));
    irq_cv: cover property (@(posedge pclk) $rose(channel_irq));
endmodule
`default_nettype wire

// >>> bench/dcp_sw_model.sv
// Purpose: Software side that programs the channel over APB
// Assumes: pready is sampled at the pclk rise that ends the access
// Notes:   An idle bus shows junk so stale values cannot pass
`timescale 1ns/1ps
`default_nettype none
module dcp_sw_model import dcp_pkg::*; (
    // APB master side
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata
);
    int junk = 21;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= $random(junk);
    endtask

    // Values, then period, then mode, then start
    task automatic setup(input logic [15:0] p, s, per0, per1,
                         input logic [31:0] ctl, input logic [1:0] run);
        logic [31:0] q;
        xfer(1'b1, tbctl_off, 32'h0, q);
        xfer(1'b1, count0_off, 32'h0, q);
        xfer(1'b1, count1_off, 32'h0, q);
        xfer(1'b1, primary_off, {16'h0, p}, q);
        xfer(1'b1, secondary_off, {16'h0, s}, q);
        xfer(1'b1, period0_off, {16'h0, per0}, q);
        xfer(1'b1, period1_off, {16'h0, per1}, q);
        xfer(1'b1, status_off, 32'h3, q);
        xfer(1'b1, ctrl_off, ctl, q);
        xfer(1'b1, tbctl_off, {30'h0, run}, q);
    endtask
endmodule
`default_nettype wire

// >>> bench/dual_compare_pulse_channel_tb.sv
// Purpose: Self-checking bench for the dual compare pulse channel
// Assumes: Zero-wait APB slave, pin and flag timing per hand-over
// Notes:   Pin timing is measured against a free cycle counter
`timescale 1ns/1ps
`default_nettype none
module dual_compare_pulse_channel_tb import dcp_pkg::*; ();
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        pslverr;
    logic        pin;
    logic        irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [32:0] expq[$];
    int          fails = 0;
    int          compares = 0;
    int          cycles = 0;
    int          seed = 21;

    dcp_channel #(.W(16)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .compare_output_pin(pin), .channel_irq(irq));
    dcp_sw_model sw (.pclk(pclk), .pready(pready), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [32:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Read results matched in bus order
    always @(posedge pclk) begin
        cycles++;
        if (presetn && psel && penable && pready && !pwrite) begin
            check("read", {pslverr, prdata}, expq.pop_front());
        end
        if (cycles == 6000) begin
            fails++;
            stop_test();
        end
    end

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        logic [31:0] q;
        expq.push_back(e);
        sw.xfer(1'b0, a, 32'h0, q);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        sw.xfer(1'b1, a, d, q);
    endtask

    task automatic wait_pin(input logic v);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (pin !== v && n < 500);
    endtask

    // Pin must stay at v with no interrupt for n cycles
    task automatic hold(input string name, input logic v, input int n);
        int bad;
        bad = 0;
        repeat (n) begin
            @(posedge pclk);
            #1;
            if (pin !== v || irq !== 1'b0) bad++;
        end
        check(name, 33'(bad), 33'h0);
    endtask

    // One pulse: width, flag delay, then flag cleared again
    task automatic pulse(input int w, output int t_rise);
        int n;
        wait_pin(1'b1);
        t_rise = cycles;
        wait_pin(1'b0);
        check("pulse width", 33'(cycles - t_rise), 33'(w));
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (irq !== 1'b1 && n < 8);
        check("flag delay", 33'(n), 33'(flag_delay));
        wr(status_off, 32'h3);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        int p, s, per, t1, t2;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(ctrl_off, 33'h0);
        rd(status_off, 33'h0);
        rd(8'hfc, {1'b1, 32'h0});
        repeat (2) begin
            p = 2 + {$random(seed)} % 4;
            s = p + 2 + {$random(seed)} % 4;
            per = s + 8 + {$random(seed)} % 8;
            sw.setup(16'(p), 16'(s), 16'(per), 16'(per),
                     {29'h0, mode_single}, 2'b01);
            pulse(s - p, t1);
            hold("single done", 1'b0, 2 * per + 4);
            wr(ctrl_off, {29'h0, mode_single});
            pulse(s - p, t1);
            wr(ctrl_off, {29'h0, mode_cont});
            pulse(s - p, t1);
            pulse(s - p, t2);
            check("train", 33'(t2 - t1), 33'(per + 1));
            wr(ctrl_off, 32'h0);
            hold("mode off", 1'b0, 2 * per);
        end
        sw.setup(16'd7, 16'd3, 16'd12, 16'd12, {29'h0, mode_single}, 2'b01);
        pulse(9, t1);
        sw.setup(16'd4, 16'd12, 16'd10, 16'd10, {29'h0, mode_cont}, 2'b01);
        wait_pin(1'b1);
        hold("no fall", 1'b1, 30);
        sw.setup(16'd0, 16'd0, 16'd0, 16'd0, {29'h0, mode_cont}, 2'b01);
        hold("all zero", 1'b0, 30);
        sw.setup(16'd20, 16'd8, 16'd10, 16'd10, {29'h0, mode_cont}, 2'b01);
        hold("beyond period", 1'b0, 40);
        sw.setup(16'd0, 16'd5, 16'd10, 16'd10, {29'h0, mode_single}, 2'b01);
        hold("first lap", 1'b0, 10);
        pulse(5, t1);
        sw.setup(16'd3, 16'd6, 16'd40, 16'd12,
                 {28'h0, 1'b1, mode_cont}, 2'b11);
        pulse(3, t1);
        pulse(3, t2);
        check("base select", 33'(t2 - t1), 33'd13);
        wr(status_off, 32'h0);
        wait_pin(1'b1);
        wait_pin(1'b0);
        repeat (3) @(posedge pclk);
        #1;
        check("irq gated", 33'(irq), 33'h0);
        rd(status_off, {1'b0, 32'h1});
        @(posedge pclk);
        stop_test();
    end
endmodule
`default_nettype wire
